// ==== src/gcs_pkg.sv ====
package gcs_pkg;
    localparam int CLK_NS = 10;
    localparam int DUR_STEP_NS = 25;
    localparam int FW_STEP_NS = 50;
    localparam int PROT_STEP_NS = 240;
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_ONCUR = 12'h004;
    localparam logic [11:0] A_OFFCUR = 12'h008;
    localparam logic [11:0] A_ONTIM = 12'h00c;
    localparam logic [11:0] A_OFFTIM = 12'h010;
    localparam logic [11:0] A_FWTIM = 12'h014;
    localparam logic [11:0] A_STAT = 12'h018;
    localparam logic [31:0] CTRL_RST = 32'h00044400;
    localparam logic [31:0] ZERO32 = 32'h00000000;
    localparam int C_FAST = 0;
    localparam int C_RANGE = 1;
    localparam int C_DIAG = 2;
    localparam int C_HOLD = 3;
    localparam int C_FWI = 5;
    localparam int C_STI = 8;
    localparam int C_APROT = 11;
    localparam int C_FPROT = 15;
    localparam int F0 = 0;
    localparam int F1 = 6;
    localparam int F2 = 12;
    localparam int F3 = 18;
    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;
    typedef enum logic [2:0] {
        K_HOLD = 3'h0, K_ACT = 3'h1, K_FW = 3'h2, K_STAT = 3'h3, K_DMAX = 3'h4
    } gcs_kind_t;
    typedef struct packed {
        logic charge;
        gcs_kind_t kind;
        logic [5:0] code;
    } gcs_sel_t;
    typedef enum logic [11:0] {
        S_IDLE = 12'h001, S_PRE = 12'h002, S_CHG = 12'h004, S_MIL = 12'h008,
        S_POST = 12'h010, S_ON = 12'h020, S_FWON = 12'h040, S_PREOFF = 12'h080,
        S_DIS = 12'h100, S_POSTOFF = 12'h200, S_STAT = 12'h400, S_FWOFF = 12'h800
    } gcs_state_t;
endpackage : gcs_pkg

// ==== src/gcs_top.sv ====
`timescale 1ns/1ns
module gcs_top
    import gcs_pkg::*;
#(
    parameter int CW = 10
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic power_up_mode,
    input wire logic hs_ctrl,
    input wire logic ls_ctrl,
    input wire logic phase_above_high,
    input wire logic phase_above_low,
    input wire logic diag_off,
    input wire logic ramp_done,
    output gcs_sel_t hs_sel,
    output gcs_sel_t ls_sel,
    output logic range_sel,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // cycles for (code+1) steps, rounded up, minus one (down-counter load value)
    function automatic logic [CW-1:0] cyc(input logic [5:0] code, input int step);
        int ns;
        ns = (int'(code) + 1) * step;
        return CW'((ns + CLK_NS - 1) / CLK_NS - 1);
    endfunction : cyc

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : wmerge

    // input synchronisers
    logic [5:0] sy1_r;
    logic [5:0] sy2_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sy1_r <= 6'h00;
            sy2_r <= 6'h00;
        end else begin
            sy1_r <= {ramp_done, diag_off, phase_above_low, phase_above_high, ls_ctrl, hs_ctrl};
            sy2_r <= sy1_r;
        end
    end
    wire hs_s = sy2_r[0];
    wire ls_s = sy2_r[1];
    wire ahi_s = sy2_r[2];
    wire alo_s = sy2_r[3];
    wire diag_s = sy2_r[4];
    wire ramp_s = sy2_r[5];

    // registers
    logic [31:0] ctrl_r;
    logic [31:0] oncur_r;
    logic [31:0] offcur_r;
    logic [31:0] ontim_r;
    logic [31:0] offtim_r;
    logic [31:0] fwtim_r;
    wire fast = ctrl_r[C_FAST];
    wire diag_sp = ctrl_r[C_DIAG];
    wire [1:0] hold_c = ctrl_r[C_HOLD +: 2];
    wire [2:0] fw_c = ctrl_r[C_FWI +: 3];
    wire [2:0] st_c = ctrl_r[C_STI +: 3];
    wire [3:0] aprot_c = ctrl_r[C_APROT +: 4];
    wire [3:0] fprot_c = ctrl_r[C_FPROT +: 4];

    // axi write
    wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    wire w_ctrl = wr_go && s_axi_awaddr == A_CTRL;
    wire w_oncur = wr_go && s_axi_awaddr == A_ONCUR;
    wire w_offcur = wr_go && s_axi_awaddr == A_OFFCUR;
    wire w_ontim = wr_go && s_axi_awaddr == A_ONTIM;
    wire w_offtim = wr_go && s_axi_awaddr == A_OFFTIM;
    wire w_fwtim = wr_go && s_axi_awaddr == A_FWTIM;
    wire w_hit = w_ctrl | w_oncur | w_offcur | w_ontim | w_offtim | w_fwtim | (s_axi_awaddr == A_STAT);
    logic [31:0] ctrl_nxt;
    // byte-lane merges, one per register
    wire [31:0] on_cur_m = wmerge(oncur_r, s_axi_wdata, s_axi_wstrb);
    wire [31:0] off_cur_m = wmerge(offcur_r, s_axi_wdata, s_axi_wstrb);
    wire [31:0] on_tim_m = wmerge(ontim_r, s_axi_wdata, s_axi_wstrb);
    wire [31:0] off_tim_m = wmerge(offtim_r, s_axi_wdata, s_axi_wstrb);
    wire [31:0] fw_tim_m = wmerge(fwtim_r, s_axi_wdata, s_axi_wstrb);
    always_comb begin
        ctrl_nxt = wmerge(ctrl_r, s_axi_wdata, s_axi_wstrb);
        if (!power_up_mode) begin
            ctrl_nxt[C_FAST] = ctrl_r[C_FAST];
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
            oncur_r <= ZERO32;
            offcur_r <= ZERO32;
            ontim_r <= ZERO32;
            offtim_r <= ZERO32;
            fwtim_r <= ZERO32;
        end else begin
            if (w_ctrl) ctrl_r <= {13'h0000, ctrl_nxt[18:0]};
            if (w_oncur) oncur_r <= {8'h00, on_cur_m[23:0]};
            if (w_offcur) offcur_r <= {14'h0000, off_cur_m[17:0]};
            if (w_ontim) ontim_r <= {8'h00, on_tim_m[23:0]};
            if (w_offtim) offtim_r <= {8'h00, off_tim_m[23:0]};
            if (w_fwtim) fwtim_r <= {26'h0000000, fw_tim_m[5:0]};
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OK;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_hit ? RESP_OK : RESP_ERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // sequencer state
    gcs_state_t st_r;
    gcs_state_t st_nxt;
    logic side_hs_r;
    logic side_nxt;
    logic fw_r;
    logic fw_nxt;
    logic [CW-1:0] ph_r;
    logic [CW-1:0] ph_nxt;
    logic [CW-1:0] prot_r;
    logic [CW-1:0] prot_nxt;

    // axi read
    wire [31:0] stat_w = {16'h0000, prot_r != '0, fw_r, side_hs_r, 1'b0, st_r};
    logic [31:0] rd_mux;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            A_CTRL: rd_mux = ctrl_r;
            A_ONCUR: rd_mux = oncur_r;
            A_OFFCUR: rd_mux = offcur_r;
            A_ONTIM: rd_mux = ontim_r;
            A_OFFTIM: rd_mux = offtim_r;
            A_FWTIM: rd_mux = fwtim_r;
            A_STAT: rd_mux = stat_w;
            default: begin
                rd_mux = ZERO32;
                rd_hit = 1'b0;
            end
        endcase
    end
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= ZERO32;
            s_axi_rresp <= RESP_OK;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? RESP_OK : RESP_ERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // phase codes
    wire [5:0] i_pre = oncur_r[F0 +: 6];
    wire [5:0] i_mil = oncur_r[F1 +: 6];
    wire [5:0] i_post = oncur_r[F2 +: 6];
    wire [5:0] i_com = oncur_r[F3 +: 6];
    wire [5:0] i_pdis = offcur_r[F0 +: 6];
    wire [5:0] i_sdis = offcur_r[F1 +: 6];
    wire [5:0] i_coff = offcur_r[F2 +: 6];
    wire [CW-1:0] t_pre = cyc(ontim_r[F0 +: 6], DUR_STEP_NS);
    wire [CW-1:0] t_chg = cyc(ontim_r[F1 +: 6], DUR_STEP_NS);
    wire [CW-1:0] t_bf = CW'(cyc(ontim_r[F2 +: 6], DUR_STEP_NS) + cyc(ontim_r[F3 +: 6], DUR_STEP_NS) + 1);
    wire [CW-1:0] t_pdis = cyc(offtim_r[F0 +: 6], DUR_STEP_NS);
    wire [CW-1:0] t_dis = cyc(offtim_r[F1 +: 6], DUR_STEP_NS);
    wire [CW-1:0] t_podis = cyc(offtim_r[F2 +: 6], DUR_STEP_NS);
    wire [CW-1:0] t_tmo = cyc(offtim_r[F3 +: 6], DUR_STEP_NS);
    wire [CW-1:0] t_fw = cyc(fwtim_r[5:0], FW_STEP_NS);
    wire [CW-1:0] t_aprot = cyc({2'b00, aprot_c}, PROT_STEP_NS);
    wire [CW-1:0] t_fprot = cyc({2'b00, fprot_c}, PROT_STEP_NS);

    wire ph_done = ph_r == '0;
    wire prot_done = prot_r == '0;
    wire own_ctrl = side_hs_r ? hs_s : ls_s;
    wire off_req = !own_ctrl || diag_s;
    wire hs_req = hs_s && !ls_s && !diag_s;
    wire ls_req = ls_s && !hs_s && !diag_s;
    // first threshold ends charge, second ends miller
    wire thr1 = side_hs_r ? alo_s : !ahi_s;
    wire thr2 = side_hs_r ? ahi_s : !alo_s;
    wire hs_is_fw = ahi_s;
    wire ls_is_fw = !alo_s;

    always_comb begin
        st_nxt = st_r;
        side_nxt = side_hs_r;
        fw_nxt = fw_r;
        ph_nxt = ph_done ? ph_r : CW'(ph_r - 1'b1);
        prot_nxt = prot_done ? prot_r : CW'(prot_r - 1'b1);
        case (st_r)
            S_IDLE: begin
                if (prot_done && (hs_req || ls_req)) begin
                    side_nxt = hs_req;
                    fw_nxt = hs_req ? hs_is_fw : ls_is_fw;
                    if (hs_req ? hs_is_fw : ls_is_fw) begin
                        st_nxt = S_FWON;
                        ph_nxt = t_fw;
                    end else begin
                        st_nxt = S_PRE;
                        ph_nxt = t_pre;
                    end
                end
            end
            S_PRE, S_CHG, S_MIL, S_POST, S_FWON, S_ON: begin
                if (off_req) begin
                    prot_nxt = fw_r ? t_fprot : t_aprot;
                    ph_nxt = fw_r ? (fast ? t_pdis : t_fw) : t_pdis;
                    st_nxt = (fw_r && !fast) ? S_FWOFF : S_PREOFF;
                end else begin
                    case (st_r)
                        S_PRE: begin
                            if (fast && thr1) begin
                                st_nxt = S_MIL;
                            end else if (ph_done) begin
                                st_nxt = fast ? S_CHG : S_CHG;
                                ph_nxt = t_chg;
                            end
                        end
                        S_CHG: begin
                            if (fast ? thr1 : ph_done) begin
                                st_nxt = fast ? S_MIL : S_POST;
                                ph_nxt = t_bf;
                            end
                        end
                        S_MIL: begin
                            if (thr2) begin
                                st_nxt = S_POST;
                                ph_nxt = t_bf;
                            end
                        end
                        S_POST: begin
                            if (ph_done && (ramp_s || !fast)) begin
                                st_nxt = S_ON;
                            end
                        end
                        S_FWON: begin
                            if (ph_done) begin
                                st_nxt = S_ON;
                            end
                        end
                        default: st_nxt = st_r;
                    endcase
                end
            end
            S_PREOFF: begin
                if (ph_done) begin
                    if (fw_r) begin
                        st_nxt = S_FWOFF;
                        ph_nxt = t_tmo;
                    end else if (diag_s && diag_sp) begin
                        st_nxt = S_STAT;
                    end else begin
                        st_nxt = S_DIS;
                        ph_nxt = t_dis;
                    end
                end
            end
            S_DIS: begin
                if (fast ? thr1 : ph_done) begin
                    st_nxt = S_POSTOFF;
                    ph_nxt = t_podis;
                end
            end
            S_POSTOFF: begin
                if (ph_done) begin
                    st_nxt = S_IDLE;
                end
            end
            S_STAT: begin
                if (prot_done) begin
                    st_nxt = S_IDLE;
                end
            end
            S_FWOFF: begin
                if (ph_done) begin
                    st_nxt = S_IDLE;
                end
            end
            default: st_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= S_IDLE;
            side_hs_r <= 1'b0;
            fw_r <= 1'b0;
            ph_r <= '0;
            prot_r <= '0;
        end else begin
            st_r <= st_nxt;
            side_hs_r <= side_nxt;
            fw_r <= fw_nxt;
            ph_r <= ph_nxt;
            prot_r <= prot_nxt;
        end
    end

    // current selection for switching gate and opposite gate
    gcs_sel_t own_w;
    gcs_sel_t opp_w;
    wire gcs_sel_t hold_off = '{charge: 1'b0, kind: K_HOLD, code: {4'h0, hold_c}};
    wire gcs_sel_t dmax = '{charge: 1'b0, kind: K_DMAX, code: 6'h3f};
    always_comb begin
        own_w = hold_off;
        opp_w = hold_off;
        case (st_r)
            S_PRE: begin
                own_w = '{charge: 1'b1, kind: K_ACT, code: i_pre};
                opp_w = dmax;
            end
            S_CHG: begin
                own_w = '{charge: 1'b1, kind: K_ACT, code: fast ? i_com : i_mil};
                opp_w = dmax;
            end
            S_MIL: begin
                own_w = '{charge: 1'b1, kind: K_ACT, code: i_mil};
                opp_w = dmax;
            end
            S_POST: begin
                own_w = '{charge: 1'b1, kind: K_ACT, code: i_post};
                opp_w = dmax;
            end
            S_ON: own_w = '{charge: 1'b1, kind: K_HOLD, code: {4'h0, hold_c}};
            S_FWON: begin
                own_w = '{charge: 1'b1, kind: K_FW, code: {3'h0, fw_c}};
                opp_w = dmax;
            end
            S_PREOFF: own_w = '{charge: 1'b0, kind: K_ACT, code: i_pdis};
            S_DIS: own_w = '{charge: 1'b0, kind: K_ACT, code: i_sdis};
            S_POSTOFF: own_w = fast ? '{charge: 1'b0, kind: K_ACT, code: i_coff} : dmax;
            S_STAT: own_w = '{charge: 1'b0, kind: K_STAT, code: {3'h0, st_c}};
            S_FWOFF: own_w = '{charge: 1'b0, kind: K_FW, code: {3'h0, fw_c}};
            default: own_w = hold_off;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hs_sel <= '{charge: 1'b0, kind: K_HOLD, code: 6'h00};
            ls_sel <= '{charge: 1'b0, kind: K_HOLD, code: 6'h00};
            range_sel <= 1'b0;
        end else begin
            hs_sel <= side_hs_r ? own_w : opp_w;
            ls_sel <= side_hs_r ? opp_w : own_w;
            range_sel <= ctrl_r[C_RANGE];
        end
    end
endmodule : gcs_top

// ==== dv/gcs_sva.sv ====
`timescale 1ns/1ns
module gcs_sva
    import gcs_pkg::*;
#(
    parameter int CW = 10
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hs_ctrl,
    input wire gcs_sel_t hs_sel,
    input wire gcs_sel_t ls_sel,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    bresp_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    wr_take_a:
        assert property (s_axi_awready |-> s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_wready)
        else $error("write taken out of turn");
    wr_resp_a:
        assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write response late");
    rd_ready_a:
        assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready wrong");
    rd_resp_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    rdata_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed while waiting");
    hs_opp_max_a:
        assert property (hs_sel.charge && hs_sel.kind != K_HOLD |-> ls_sel.kind == K_DMAX && !ls_sel.charge)
        else $error("low side not at max discharge");
    ls_opp_max_a:
        assert property (ls_sel.charge && ls_sel.kind != K_HOLD |-> hs_sel.kind == K_DMAX && !hs_sel.charge)
        else $error("high side not at max discharge");
    no_shoot_a:
        assert property (!(hs_sel.charge && ls_sel.charge))
        else $error("both gates charged");
    dmax_code_a:
        assert property (hs_sel.kind == K_DMAX |-> hs_sel.code == 6'h3f)
        else $error("max discharge code wrong");
    hold_code_a:
        assert property (hs_sel.kind == K_HOLD |-> hs_sel.code[5:2] == 4'h0)
        else $error("hold code out of range");
    fw_code_a:
        assert property (ls_sel.kind inside {K_FW, K_STAT} |-> ls_sel.code[5:3] == 3'h0)
        else $error("freewheel code out of range");
    sync_delay_a:
        assert property ($rose(hs_ctrl) |=> $stable(hs_sel))
        else $error("control acted before synchronizer");
endmodule : gcs_sva

// ==== dv/gcs_stage_model.sv ====
`timescale 1ns/1ns
module gcs_stage_model
    import gcs_pkg::*;
#(
    parameter int DLY = 3
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire gcs_sel_t hs_sel,
    input wire gcs_sel_t ls_sel,
    output logic phase_above_high,
    output logic phase_above_low,
    output logic ramp_done
);
    logic [1:0] lvl_r;
    int dly_r;
    int ramp_r;
    gcs_sel_t last_r;
    assign phase_above_low = lvl_r != 2'h0;
    assign phase_above_high = lvl_r == 2'h2;
    assign ramp_done = ramp_r >= DLY;
    // phase slews one threshold per DLY+1 cycles, up while hs_sel.charge is set, down otherwise
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lvl_r <= 2'h0;
            dly_r <= 0;
        end else if (dly_r < DLY) begin
            dly_r <= dly_r + 1;
        end else begin
            dly_r <= 0;
            if (hs_sel.charge && lvl_r != 2'h2) lvl_r <= lvl_r + 2'h1;
            else if (!hs_sel.charge && lvl_r != 2'h0) lvl_r <= lvl_r - 2'h1;
        end
    end
    always_ff @(posedge sys_clk) begin
        last_r <= hs_sel;
        ramp_r <= (hs_sel != last_r) ? 0 : ramp_r + 1;
    end
endmodule : gcs_stage_model

// ==== dv/gcs_top_test.sv ====
`timescale 1ns/1ns
module gcs_top_test;
    import gcs_pkg::*;
    logic sys_clk, rst, power_up_mode, hs_ctrl, ls_ctrl, diag_off, range_sel;
    logic phase_above_high, phase_above_low, ramp_done;
    gcs_sel_t hs_sel, ls_sel;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int err_total = 0;
    int checks = 0;
    gcs_top #(.CW(10)) gcs_top_inst (.*);
    gcs_stage_model gcs_stage_model_inst (.*);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task stop_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task lim(input int n);
        if (n >= 400) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, n, 0);
            stop_test();
        end
    endtask : lim
    function automatic int cyc(input int c, input int st);
        return ((c + 1) * st + CLK_NS - 1) / CLK_NS;
    endfunction : cyc
    function automatic logic [31:0] sel(input logic c, input gcs_kind_t k, input logic [5:0] d);
        gcs_sel_t s;
        s = '{c, k, d};
        return {22'h0, s};
    endfunction : sel
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin @(negedge sys_clk); n++; end while (!s_axi_awready && n < 400);
        lim(n);
        @(posedge sys_clk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do begin @(negedge sys_clk); n++; end while (!s_axi_bvalid && n < 400);
        lim(n);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge sys_clk);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin @(negedge sys_clk); n++; end while (!s_axi_arready && n < 400);
        lim(n);
        @(posedge sys_clk);
        s_axi_arvalid <= 1'b0;
        do begin @(negedge sys_clk); n++; end while (!s_axi_rvalid && n < 400);
        lim(n);
        chk(s_axi_rdata, d);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge sys_clk);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic span(input bit hs, input logic [31:0] s, output int k);
        int n;
        n = 0;
        k = 0;
        while ({22'h0, hs ? hs_sel : ls_sel} !== s && n < 400) begin @(negedge sys_clk); n++; end
        lim(n);
        while ({22'h0, hs ? hs_sel : ls_sel} === s && k < 400) begin @(negedge sys_clk); k++; end
    endtask : span
    task t_regs;
        @(negedge sys_clk);
        chk({22'h0, hs_sel}, 32'h0);
        chk({31'h0, range_sel}, 32'h0);
        rd(A_CTRL, CTRL_RST, RESP_OK);
        rd(12'h01c, ZERO32, RESP_ERR);
        wr(12'h01c, 32'h00000001, RESP_ERR);
        wr(A_CTRL, 32'h00001871, RESP_OK);
        rd(A_CTRL, 32'h00001870, RESP_OK);
        wr(A_CTRL, 32'h00001872, RESP_OK);
        repeat (2) @(negedge sys_clk);
        chk({31'h0, range_sel}, 32'h1);
        wr(A_CTRL, 32'h00001870, RESP_OK);
        wr(A_ONCUR, 32'h00011285, RESP_OK);
        wr(A_OFFCUR, 32'h00000307, RESP_OK);
        wr(A_ONTIM, 32'h000410c1, RESP_OK);
        wr(A_OFFTIM, 32'h000410c1, RESP_OK);
        wr(A_FWTIM, 32'h00000002, RESP_OK);
        repeat (2) @(negedge sys_clk);
        chk({31'h0, range_sel}, 32'h0);
        $display("test registers done");
    endtask : t_regs
    task t_on;
        int k;
        @(posedge sys_clk);
        hs_ctrl <= 1'b1;
        span(1'b1, sel(1'b1, K_ACT, 6'h05), k);
        chk(k, cyc(1, DUR_STEP_NS));
        span(1'b1, sel(1'b1, K_ACT, 6'h0a), k);
        chk(k, cyc(3, DUR_STEP_NS));
        span(1'b1, sel(1'b1, K_ACT, 6'h11), k);
        chk(k, 2 * cyc(1, DUR_STEP_NS));
        chk({22'h0, hs_sel}, sel(1'b1, K_HOLD, 6'h02));
        chk({22'h0, ls_sel}, sel(1'b0, K_HOLD, 6'h02));
        $display("test active on done");
    endtask : t_on
    task t_off;
        int k;
        time t0;
        @(posedge sys_clk);
        hs_ctrl <= 1'b0;
        ls_ctrl <= 1'b1;
        t0 = $time;
        span(1'b1, sel(1'b0, K_ACT, 6'h07), k);
        chk(k, cyc(1, DUR_STEP_NS));
        span(1'b1, sel(1'b0, K_ACT, 6'h0c), k);
        chk(k, cyc(3, DUR_STEP_NS));
        span(1'b1, sel(1'b0, K_DMAX, 6'h3f), k);
        chk(k, cyc(1, DUR_STEP_NS));
        chk({22'h0, hs_sel}, sel(1'b0, K_HOLD, 6'h02));
        span(1'b0, sel(1'b1, K_FW, 6'h03), k);
        chk(k, cyc(2, FW_STEP_NS));
        chk({31'h0, ($time - t0) / CLK_NS - k >= 4 * PROT_STEP_NS / CLK_NS}, 32'h1);
        chk({22'h0, ls_sel}, sel(1'b1, K_HOLD, 6'h02));
        chk({22'h0, hs_sel}, sel(1'b0, K_HOLD, 6'h02));
        @(posedge sys_clk);
        ls_ctrl <= 1'b0;
        span(1'b0, sel(1'b0, K_FW, 6'h03), k);
        chk(k, cyc(2, FW_STEP_NS));
        chk({22'h0, ls_sel}, sel(1'b0, K_HOLD, 6'h02));
        $display("test active off done");
    endtask : t_off
    task t_diag;
        int k;
        @(posedge sys_clk);
        power_up_mode <= 1'b1;
        wr(A_CTRL, 32'h00001b75, RESP_OK);
        rd(A_CTRL, 32'h00001b75, RESP_OK);
        wr(A_CTRL, 32'h00001b74, RESP_OK);
        power_up_mode <= 1'b0;
        @(posedge sys_clk);
        hs_ctrl <= 1'b1;
        span(1'b1, sel(1'b1, K_ACT, 6'h05), k);
        chk(k, cyc(1, DUR_STEP_NS));
        @(posedge sys_clk);
        diag_off <= 1'b1;
        span(1'b1, sel(1'b0, K_ACT, 6'h07), k);
        chk(k, cyc(1, DUR_STEP_NS));
        span(1'b1, sel(1'b0, K_STAT, 6'h03), k);
        chk(k, cyc(3, PROT_STEP_NS) - cyc(1, DUR_STEP_NS));
        chk({22'h0, hs_sel}, sel(1'b0, K_HOLD, 6'h02));
        @(posedge sys_clk);
        hs_ctrl <= 1'b0;
        diag_off <= 1'b0;
        $display("test diagnostic off done");
    endtask : t_diag
    initial begin
        rst = 1'b1;
        power_up_mode = 1'b0;
        hs_ctrl = 1'b0;
        ls_ctrl = 1'b0;
        diag_off = 1'b0;
        s_axi_awaddr = 12'h000;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 12'h000;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_on();
        t_off();
        t_diag();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        lim(400);
    end
endmodule : gcs_top_test
bind gcs_top gcs_sva #(.CW(CW)) gcs_sva_inst (.*);
